// >>> spbo_pkg.sv
// Constants for the serial port register front end
// Assumes an AXI4-Lite master on one clock, sys_clk at 250 MHz
package spbo_pkg;
  localparam logic [1:0]  BUS_REV2       = 2'h0;
  localparam logic [1:0]  BUS_REV3       = 2'h1;
  localparam logic [1:0]  BUS_REV4       = 2'h2;
  localparam int          DEPTH_DEFAULT  = 16;
  localparam int          DEPTH_INT_MAX  = 256;
  localparam logic [2:0]  PRIV_INIT      = 3'h2;
  localparam int          TMO_W_DEFAULT  = 4;
  localparam logic [8:0]  TMO_INIT       = 9'h008;
  localparam logic [3:0]  SYNC_STAGES    = 4'h2;
  localparam logic [1:0]  CLK_SINGLE     = 2'h1;
  localparam logic [1:0]  CLK_DUAL       = 2'h2;
  localparam logic [11:0] A_DATA         = 12'h000;
  localparam logic [11:0] A_XCVR         = 12'h004;
  localparam logic [11:0] A_PRIV         = 12'h008;
  localparam logic [11:0] A_TMO          = 12'h00C;
  localparam logic [11:0] A_STATUS       = 12'h010;
  localparam logic [11:0] A_CONFIG       = 12'h014;
  localparam int          XC_MODE_BIT    = 0;
  localparam int          XC_DRIVE_BIT   = 1;
  localparam int          XC_LISTEN_BIT  = 2;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;
  localparam logic [8:0]  ADDR_MARK      = 9'h100;
endpackage : spbo_pkg

// >>> spbo_fifo.sv
// Nine-bit character FIFO with flop storage and registered read data
// Assumes one clock; pushes ignored when full, pops when empty
`timescale 1ns/10ps
module spbo_fifo #(
  parameter int W     = 9,
  parameter int DEPTH = 16
) (
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  input  wire logic         push,
  input  wire logic [W-1:0] push_data,
  input  wire logic         pop,
  output logic [W-1:0]      pop_data,
  output logic              full,
  output logic              empty
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wp;
    logic [AW-1:0]           rp;
    logic [AW:0]             cnt;
    logic [W-1:0]            q;
  } spbo_fifo_t;
  spbo_fifo_t st;
  spbo_fifo_t next_st;
  logic do_push;
  logic do_pop;
  assign full    = (st.cnt == (AW+1)'(DEPTH));
  assign empty   = (st.cnt == '0);
  assign do_push = push && !full;
  assign do_pop  = pop && !empty;
  assign pop_data = st.q;
  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(DEPTH-1)) ? '0 : p + AW'(1);
  endfunction : bump
  always_comb begin
    next_st = st;
    if (do_push) begin
      next_st.mem[st.wp] = push_data;
      next_st.wp = bump(st.wp);
    end
    // Synchronous read port
    if (do_pop) begin
      next_st.q  = st.mem[st.rp];
      next_st.rp = bump(st.rp);
    end
    next_st.cnt = st.cnt + (AW+1)'(do_push) - (AW+1)'(do_pop);
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  chk_fifo_count_bound: assert property (@(posedge sys_clk) disable iff (!rst_n)
    st.cnt <= (AW+1)'(DEPTH)) else $error("fifo count over depth");
endmodule : spbo_fifo

// >>> spbo_top.sv
// Register front end of a configurable serial port: AXI4-Lite slave,
// stalls on empty receive or full transmit FIFO only with the timeout register, timeout error,
// privilege protection and two-wire transceiver enables.
// Assumes the serial engine drains tx and fills rx over plain strobes.
//
// The register offsets and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/10ps
module spbo_top
  import spbo_pkg::*;
#(
  parameter logic [1:0] BUS_VARIANT     = spbo_pkg::BUS_REV2,
  parameter int         FIFO_DEPTH      = spbo_pkg::DEPTH_DEFAULT,
  parameter bit         MEM_INTERNAL    = 1'b0,
  parameter bit         ERROR_REPLY     = 1'b0,
  parameter logic [2:0] PRIV_INITIAL    = spbo_pkg::PRIV_INIT,
  parameter bit         PRIV_FIXED      = 1'b0,
  parameter int         TMO_WIDTH       = (BUS_VARIANT != spbo_pkg::BUS_REV2 && ERROR_REPLY
                                          && FIFO_DEPTH != 0) ? spbo_pkg::TMO_W_DEFAULT : 0,
  parameter bit         TMO_FIXED       = 1'b0,
  parameter logic [8:0] TMO_START       = spbo_pkg::TMO_INIT,
  parameter bit         XCVR_OPTION     = 1'b0,
  parameter bit         DRIVE_POL       = 1'b1,
  parameter bit         LISTEN_POL      = 1'b1,
  parameter bit         NINE_BIT        = 1'b0,
  parameter int         DATA_W          = 32,
  parameter bit         IR_LP_TX        = 1'b0,
  parameter bit         IR_LP_RX        = 1'b0,
  parameter logic [1:0] CLOCK_SCHEME    = spbo_pkg::CLK_SINGLE,
  parameter logic [3:0] SYNC_DEPTH      = spbo_pkg::SYNC_STAGES,
  parameter bit         AUTO_FLOW       = 1'b0
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [8:0]       tx_char,
  output logic             tx_char_valid,
  input  wire logic        tx_char_take,
  input  wire logic [8:0]  rx_char,
  input  wire logic        rx_char_valid,
  output logic             rx_fifo_full,
  output logic             tx_drive_out,
  output logic             rx_listen_out,
  output logic             xcvr_mode_on,
  output logic             serial_clk_needed,
  output logic             auto_flow_active
);
  localparam int  CW       = 9;
  localparam int  DEPTH    = (FIFO_DEPTH == 0) ? 1 : FIFO_DEPTH;
  localparam bit  ERR_ON   = ERROR_REPLY && (BUS_VARIANT != BUS_REV2);
  localparam bit  PRIV_ON  = ERR_ON && (BUS_VARIANT == BUS_REV4);
  localparam bit  TMO_REG  = ERR_ON && (TMO_WIDTH != 0) && (FIFO_DEPTH != 0);
  localparam logic [8:0] TMO_PERIOD = 9'(1 << TMO_WIDTH);
  localparam logic [DATA_W-1:0] DMASK = {DATA_W{1'b1}};

  initial begin
    if (FIFO_DEPTH != 0 && (FIFO_DEPTH < 16 || FIFO_DEPTH > 2048))
      $error("fifo depth out of range");
    if (MEM_INTERNAL && FIFO_DEPTH > DEPTH_INT_MAX)
      $error("internal memory needs depth of 256 or less");
    if (BUS_VARIANT > BUS_REV4)
      $error("bad bus variant");
    if (TMO_WIDTH != 0 && (TMO_WIDTH < 4 || TMO_WIDTH > 8))
      $error("bad timer width");
    if (DATA_W != 8 && DATA_W != 16 && DATA_W != 32)
      $error("bad data width");
    if ((IR_LP_TX || IR_LP_RX) && CLOCK_SCHEME == CLK_SINGLE)
      $error("low-power infrared needs dual clock");
    if (SYNC_DEPTH < 4'h2 || SYNC_DEPTH > 4'h4)
      $error("bad sync depth");
  end

  typedef enum logic [1:0] {ST_IDLE, ST_STALL, ST_RESP} spbo_phase_t;
  typedef struct packed {
    spbo_phase_t  wph;
    spbo_phase_t  rph;
    logic [11:0]  waddr;
    logic [2:0]   wprot;
    logic         whave_a;
    logic [31:0]  wdata;
    logic [3:0]   wstrb;
    logic         whave_d;
    logic [11:0]  raddr;
    logic [2:0]   rprot;
    logic [1:0]   bresp;
    logic [31:0]  rdata;
    logic [1:0]   rresp;
    logic         rdrain;
    logic [8:0]   tmo;
    logic [8:0]   wcnt;
    logic [8:0]   rcnt;
    logic [2:0]   priv;
    logic [2:0]   xcvr;
  } spbo_state_t;
  spbo_state_t st;
  spbo_state_t next_st;

  logic       txf_push;
  logic       txf_full;
  logic       txf_empty;
  logic       rxf_pop;
  logic       rxf_empty;
  logic [8:0] rxf_q;
  logic [8:0] tx_word;
  logic [8:0] tx_q;
  logic       tx_pop;

  function automatic logic priv_ok(input logic [2:0] lvl, input logic [2:0] prot);
    priv_ok = !PRIV_ON || ((lvl & ~prot) == 3'h0);
  endfunction : priv_ok
  function automatic logic is_prot(input logic [11:0] a);
    is_prot = (a == A_DATA) || (a == A_XCVR);
  endfunction : is_prot

  spbo_fifo #(.W(CW), .DEPTH(DEPTH)) u_txf (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .push      (txf_push),
    .push_data (tx_word),
    .pop       (tx_pop),
    .pop_data  (tx_q),
    .full      (txf_full),
    .empty     (txf_empty)
  );
  spbo_fifo #(.W(CW), .DEPTH(DEPTH)) u_rxf (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .push      (rx_char_valid),
    .push_data (rx_char),
    .pop       (rxf_pop),
    .pop_data  (rxf_q),
    .full      (rx_fifo_full),
    .empty     (rxf_empty)
  );

  // Ninth bit passes through, cleared without nine-bit option
  assign tx_word = NINE_BIT ? st.wdata[8:0] : {1'b0, st.wdata[7:0]};
  assign tx_pop        = tx_char_take && !txf_empty;
  assign tx_char_valid = !txf_empty;
  assign tx_char       = tx_q;

  logic w_go;
  logic w_data;
  logic w_allow;
  logic w_blocked;
  logic w_tmo;
  logic r_go;
  logic r_data;
  logic r_allow;
  logic r_blocked;
  logic r_tmo;
  always_comb begin
    w_go      = st.whave_a && st.whave_d && (st.wph != ST_RESP);
    w_data    = (st.waddr == A_DATA);
    w_allow   = !is_prot(st.waddr) || priv_ok(st.priv, st.wprot) || !ERR_ON;
    w_blocked = w_go && w_data && w_allow && txf_full;
    w_tmo     = w_blocked && (!TMO_REG || st.wcnt <= 9'h001);
    r_go      = (st.rph == ST_STALL);
    r_data    = (st.raddr == A_DATA);
    r_allow   = !is_prot(st.raddr) || priv_ok(st.priv, st.rprot) || !ERR_ON;
    r_blocked = r_go && r_data && r_allow && rxf_empty && !st.rdrain;
    r_tmo     = r_blocked && (!TMO_REG || st.rcnt <= 9'h001);
  end
  assign txf_push = w_go && w_data && w_allow && !txf_full && (st.wstrb[0] || DATA_W == 8);
  assign rxf_pop  = r_go && r_data && r_allow && !rxf_empty && !st.rdrain;

  always_comb begin
    next_st = st;
    // Write address and data taken in either order
    if (s_axi_awvalid && s_axi_awready) begin
      next_st.waddr   = s_axi_awaddr;
      next_st.wprot   = s_axi_awprot;
      next_st.whave_a = 1'b1;
      next_st.wcnt    = TMO_REG ? st.tmo : 9'h000;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_st.wdata   = s_axi_wdata & 32'(DMASK);
      next_st.wstrb   = s_axi_wstrb;
      next_st.whave_d = 1'b1;
    end
    if (w_blocked && !w_tmo) begin
      next_st.wph  = ST_STALL;
      next_st.wcnt = st.wcnt - 9'h001;
    end else if (w_go) begin
      next_st.wph   = ST_RESP;
      next_st.bresp = RESP_OKAY;
      if ((!w_allow || w_tmo) && ERR_ON) begin
        next_st.bresp = RESP_SLVERR;
      end else if (w_allow) begin
        case (st.waddr)
          A_XCVR: begin
            if (st.wstrb[0]) next_st.xcvr = st.wdata[2:0];
          end
          A_PRIV: begin
            if (PRIV_ON && !PRIV_FIXED && st.wstrb[0]) next_st.priv = st.wdata[2:0];
          end
          A_TMO: begin
            if (TMO_REG && !TMO_FIXED) begin
              if (st.wstrb[0]) next_st.tmo[7:0] = st.wdata[7:0];
              if (st.wstrb[1]) next_st.tmo[8] = st.wdata[8];
              if (next_st.tmo > TMO_PERIOD) next_st.tmo = TMO_PERIOD;
            end
          end
          default: begin
          end
        endcase
      end
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_st.wph     = ST_IDLE;
      next_st.whave_a = 1'b0;
      next_st.whave_d = 1'b0;
    end
    // Read path: stall, then registered data
    if (s_axi_arvalid && s_axi_arready) begin
      next_st.raddr  = s_axi_araddr;
      next_st.rprot  = s_axi_arprot;
      next_st.rph    = ST_STALL;
      next_st.rdrain = 1'b0;
      next_st.rcnt   = TMO_REG ? st.tmo : 9'h000;
    end
    if (r_blocked && !r_tmo) begin
      next_st.rcnt = st.rcnt - 9'h001;
    end else if (r_go && r_data && r_allow && !r_blocked && !st.rdrain) begin
      next_st.rdrain = 1'b1;
    end else if (r_go) begin
      next_st.rph   = ST_RESP;
      next_st.rresp = RESP_OKAY;
      next_st.rdata = 32'h0000_0000;
      if ((!r_allow || r_tmo) && ERR_ON) begin
        next_st.rresp = RESP_SLVERR;
      end else begin
        case (st.raddr)
          A_DATA:   next_st.rdata = 32'(rxf_q);
          A_XCVR:   next_st.rdata = 32'(st.xcvr);
          A_PRIV:   next_st.rdata = 32'(st.priv);
          A_TMO:    next_st.rdata = 32'(st.tmo);
          A_STATUS: next_st.rdata = {28'h0000000, rx_fifo_full, rxf_empty, txf_full, txf_empty};
          A_CONFIG: next_st.rdata = {8'h00, 4'(TMO_WIDTH), SYNC_DEPTH, 4'(CLOCK_SCHEME),
                                     4'(BUS_VARIANT), 5'h00, MEM_INTERNAL, NINE_BIT, AUTO_FLOW};
          default:  next_st.rdata = 32'h0000_0000;
        endcase
        next_st.rdata = next_st.rdata & 32'(DMASK);
      end
    end
    if (s_axi_rvalid && s_axi_rready) begin
      next_st.rph = ST_IDLE;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st      <= '0;
      st.wph  <= ST_IDLE;
      st.rph  <= ST_IDLE;
      st.priv <= PRIV_ON ? PRIV_INITIAL : 3'h0;
      st.tmo  <= TMO_REG ? TMO_START : 9'h000;
    end else begin
      st <= next_st;
    end
  end

  assign s_axi_awready = !st.whave_a;
  assign s_axi_wready  = !st.whave_d;
  assign s_axi_bvalid  = (st.wph == ST_RESP);
  assign s_axi_bresp   = st.bresp;
  assign s_axi_arready = (st.rph == ST_IDLE);
  assign s_axi_rvalid  = (st.rph == ST_RESP);
  assign s_axi_rresp   = st.rresp;
  assign s_axi_rdata   = st.rdata;

  // Transceiver enables at their configured polarity
  assign xcvr_mode_on  = XCVR_OPTION && st.xcvr[XC_MODE_BIT];
  assign tx_drive_out  = XCVR_OPTION ? (st.xcvr[XC_DRIVE_BIT] ~^ DRIVE_POL) : 1'b0;
  assign rx_listen_out = XCVR_OPTION ? (st.xcvr[XC_LISTEN_BIT] ~^ LISTEN_POL) : 1'b0;
  assign serial_clk_needed = IR_LP_TX || IR_LP_RX || (CLOCK_SCHEME == CLK_DUAL);
  assign auto_flow_active  = AUTO_FLOW && (FIFO_DEPTH != 0);

  chk_stall_needs_full: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (st.wph == ST_STALL && !s_axi_bvalid) |-> $past(txf_full))
    else $error("write stalled without full fifo");
  chk_tmo_slverr: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (w_tmo && ERR_ON) |=> (s_axi_bvalid && s_axi_bresp == RESP_SLVERR))
    else $error("write timeout without error");
  chk_no_err_off: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !ERR_ON |-> (s_axi_bresp != RESP_SLVERR && s_axi_rresp != RESP_SLVERR))
    else $error("error reply while disabled");
  chk_priv_write_keep: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (w_go && !w_allow && ERR_ON) |=> ($stable(st.xcvr) && s_axi_bresp == RESP_SLVERR))
    else $error("protected write took effect");
  chk_priv_fixed_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (PRIV_FIXED || !PRIV_ON) |-> (st.priv == (PRIV_ON ? PRIV_INITIAL : 3'h0)))
    else $error("fixed privilege changed");
  chk_tmo_fixed_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (TMO_FIXED || !TMO_REG) |-> (st.tmo == (TMO_REG ? TMO_START : 9'h000)))
    else $error("fixed timer changed");
  chk_stall_restart: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (s_axi_arvalid && s_axi_arready) |=> (st.rcnt == (TMO_REG ? $past(st.tmo) : 9'h000)))
    else $error("stall timer not restarted");
  chk_zero_tmo_now: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!TMO_REG && r_blocked) |=> s_axi_rvalid)
    else $error("zero width did not time out");
  chk_drive_pol: assert property (@(posedge sys_clk) disable iff (!rst_n)
    XCVR_OPTION |-> (tx_drive_out == (st.xcvr[XC_DRIVE_BIT] ~^ DRIVE_POL)))
    else $error("drive polarity wrong");
  chk_rdata_mask: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_axi_rvalid |-> ((s_axi_rdata & ~32'(DMASK)) == 32'h0))
    else $error("unused data bits set");
  chk_drain_answer: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (r_go && st.rdrain) |=> s_axi_rvalid)
    else $error("popped read did not answer");
  chk_tmo_range: assert property (@(posedge sys_clk) disable iff (!rst_n)
    TMO_REG |-> (st.tmo <= TMO_PERIOD))
    else $error("timer value above period");
  chk_wstall_restart: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (s_axi_awvalid && s_axi_awready) |=> (st.wcnt == (TMO_REG ? $past(st.tmo) : 9'h000)))
    else $error("write stall timer not restarted");
  cov_priv_reject: cover property (@(posedge sys_clk) disable iff (!rst_n)
    w_go && !w_allow ##1 s_axi_bvalid);
  cov_write_stall: cover property (@(posedge sys_clk) disable iff (!rst_n)
    st.wph == ST_STALL ##1 s_axi_bvalid);
  cov_read_data: cover property (@(posedge sys_clk) disable iff (!rst_n)
    rxf_pop ##[1:3] s_axi_rvalid);
  cov_read_tmo: cover property (@(posedge sys_clk) disable iff (!rst_n)
    r_tmo ##1 s_axi_rvalid);
endmodule : spbo_top

// >>> spbo_line_model.sv
// Serial engine model beside the port: drains tx chars, feeds rx chars
// Assumes single sys_clk domain and one-cycle take and push strobes
`timescale 1ns/10ps
module spbo_line_model (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       stall,
  input  wire logic [8:0] tx_char,
  input  wire logic       tx_char_valid,
  output logic            tx_char_take,
  output logic [8:0]      rx_char,
  output logic            rx_char_valid
);
  logic       grab;
  logic [8:0] got[$];

  initial begin
    rx_char       = 9'h1FF;
    rx_char_valid = 1'b0;
  end

  // Pop every other cycle so the registered head settles
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_char_take <= 1'b0;
      grab         <= 1'b0;
    end else begin
      tx_char_take <= tx_char_valid && !stall && !tx_char_take;
      grab         <= tx_char_take;
      if (grab) got.push_back(tx_char);
    end
  end

  // Bit 8 set marks an address char; line scrambled when idle
  task automatic send(input logic [8:0] c);
    @(posedge sys_clk);
    rx_char       <= c;
    rx_char_valid <= 1'b1;
    @(posedge sys_clk);
    rx_char       <= ~c;
    rx_char_valid <= 1'b0;
  endtask : send
endmodule : spbo_line_model

// >>> spbo_top_tb.sv
// Self-checking bench for the serial port register front end
// Assumes AXI4-Lite master tasks and the line model on the serial side
`timescale 1ns/10ps
module spbo_top_tb;
  import spbo_pkg::*;
  localparam logic [2:0] P_OK  = 3'h2;
  localparam logic [2:0] P_BAD = 3'h0;
  logic        sys_clk, rst_n, hold_tx;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0]  s_axi_awprot, s_axi_arprot;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [8:0]  tx_char, rx_char;
  logic        tx_char_valid, tx_char_take, rx_char_valid, rx_fifo_full;
  logic        tx_drive_out, rx_listen_out, xcvr_mode_on;
  logic        serial_clk_needed, auto_flow_active;
  int          err_total, n_compared;

  spbo_top #(.BUS_VARIANT(BUS_REV4), .ERROR_REPLY(1'b1), .XCVR_OPTION(1'b1),
    .LISTEN_POL(1'b0), .NINE_BIT(1'b1)) spbo_top_i (
    .sys_clk(sys_clk), .rst_n(rst_n),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(s_axi_awprot), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arprot(s_axi_arprot), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .tx_char(tx_char), .tx_char_valid(tx_char_valid),
    .tx_char_take(tx_char_take), .rx_char(rx_char), .rx_char_valid(rx_char_valid),
    .rx_fifo_full(rx_fifo_full), .tx_drive_out(tx_drive_out), .rx_listen_out(rx_listen_out),
    .xcvr_mode_on(xcvr_mode_on), .serial_clk_needed(serial_clk_needed),
    .auto_flow_active(auto_flow_active));
  spbo_line_model spbo_line_model_i (.sys_clk(sys_clk), .rst_n(rst_n), .stall(hold_tx),
    .tx_char(tx_char), .tx_char_valid(tx_char_valid), .tx_char_take(tx_char_take),
    .rx_char(rx_char), .rx_char_valid(rx_char_valid));

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wrc(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                     input logic [2:0] p, input logic [1:0] er);
    bit done;
    done = 0;
    @(posedge sys_clk);
    s_axi_awaddr  <= a;
    s_axi_awprot  <= p;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= s;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!done) begin
      @(posedge sys_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        chk("bresp", 32'(er), 32'(s_axi_bresp));
        done = 1;
      end
    end
    s_axi_bready <= 1'b0;
  endtask : wrc

  task automatic rd(input logic [11:0] a, input logic [2:0] p, output logic [31:0] d,
                    output logic [1:0] r, output int c);
    bit done;
    done = 0;
    c    = 0;
    @(posedge sys_clk);
    s_axi_araddr  <= a;
    s_axi_arprot  <= p;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    while (!done) begin
      @(posedge sys_clk);
      c++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        d    = s_axi_rdata;
        r    = s_axi_rresp;
        done = 1;
      end
    end
    s_axi_rready <= 1'b0;
  endtask : rd

  task automatic rdc(input logic [11:0] a, input logic [2:0] p, input logic [31:0] e,
                     input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    int          c;
    rd(a, p, d, r, c);
    chk("rresp", 32'(er), 32'(r));
    if (er == RESP_OKAY) chk("rdata", e, d);
  endtask : rdc

  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : results

  initial begin
    repeat (20000) @(posedge sys_clk);
    err_total++;
    results();
  end

  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    int          c, c1;
    rst_n = 1'b0;
    hold_tx = 1'b0;
    s_axi_awaddr = 12'h000;
    s_axi_awprot = 3'h0;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'h0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 12'h000;
    s_axi_arprot = 3'h0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    chk("opts", 32'h0, {30'h0, serial_clk_needed, auto_flow_active});
    rdc(A_PRIV, P_OK, 32'h2, RESP_OKAY);
    rdc(A_TMO, P_OK, 32'h8, RESP_OKAY);
    rdc(A_STATUS, P_OK, 32'h5, RESP_OKAY);
    rdc(12'h0FC, P_OK, 32'h0, RESP_OKAY);
    rdc(A_CONFIG, P_OK, 32'h0042_1202, RESP_OKAY);
    wrc(A_DATA, 32'h1A5, 4'h3, P_BAD, RESP_SLVERR);
    rdc(A_STATUS, P_OK, 32'h5, RESP_OKAY);
    wrc(A_DATA, 32'h1A5, 4'h3, P_OK, RESP_OKAY);
    wrc(A_DATA, 32'h05A, 4'h3, P_OK, RESP_OKAY);
    repeat (12) @(posedge sys_clk);
    chk("tx count", 32'h2, spbo_line_model_i.got.size());
    chk("tx addr char", 32'h1A5, spbo_line_model_i.got[0]);
    chk("tx data char", 32'h05A, spbo_line_model_i.got[1]);
    spbo_line_model_i.got.delete();
    wrc(A_XCVR, 32'h7, 4'h1, P_OK, RESP_OKAY);
    chk("xcvr pins", 32'h6, {29'h0, xcvr_mode_on, tx_drive_out, rx_listen_out});
    wrc(A_XCVR, 32'h0, 4'h1, P_BAD, RESP_SLVERR);
    rdc(A_XCVR, P_OK, 32'h7, RESP_OKAY);
    wrc(A_XCVR, 32'h0, 4'h1, P_OK, RESP_OKAY);
    chk("xcvr pins", 32'h1, {29'h0, xcvr_mode_on, tx_drive_out, rx_listen_out});
    wrc(A_PRIV, 32'h0, 4'h1, P_OK, RESP_OKAY);
    rdc(A_PRIV, P_OK, 32'h0, RESP_OKAY);
    rdc(A_XCVR, P_BAD, 32'h0, RESP_OKAY);
    wrc(A_PRIV, 32'h4, 4'h1, P_BAD, RESP_OKAY);
    rdc(A_XCVR, 3'h3, 32'h0, RESP_SLVERR);
    wrc(A_PRIV, 32'h2, 4'h1, 3'h4, RESP_OKAY);
    wrc(A_TMO, 32'h5, 4'h3, P_OK, RESP_OKAY);
    rdc(A_TMO, P_OK, 32'h5, RESP_OKAY);
    rd(A_DATA, P_OK, d, r, c);
    chk("stall resp", 32'(RESP_SLVERR), 32'(r));
    chk("stall span", 32'h1, 32'(c >= 6 && c <= 12));
    rd(A_DATA, P_OK, d, r, c1);
    chk("stall restart", 32'(c), 32'(c1));
    fork
      rd(A_DATA, P_OK, d, r, c);
      begin
        repeat (3) @(posedge sys_clk);
        spbo_line_model_i.send(9'h0C3);
      end
    join
    chk("late resp", 32'(RESP_OKAY), 32'(r));
    chk("late data", 32'h0C3, d);
    hold_tx <= 1'b1;
    for (int i = 0; i < 16; i++) wrc(A_DATA, 32'h10 + i, 4'h3, P_OK, RESP_OKAY);
    rdc(A_STATUS, P_OK, 32'h6, RESP_OKAY);
    wrc(A_DATA, 32'h0FF, 4'h3, P_OK, RESP_SLVERR);
    hold_tx <= 1'b0;
    repeat (60) @(posedge sys_clk);
    chk("tx drained", 32'd16, spbo_line_model_i.got.size());
    for (int i = 0; i < 16; i++) chk("tx order", 32'h10 + i, spbo_line_model_i.got[i]);
    for (int i = 0; i < 17; i++) spbo_line_model_i.send(9'h120 + 9'(i));
    chk("rx full", 32'h1, {31'h0, rx_fifo_full});
    for (int i = 0; i < 16; i++) rdc(A_DATA, P_OK, 32'h120 + i, RESP_OKAY);
    rdc(A_STATUS, P_OK, 32'h5, RESP_OKAY);
    results();
  end
endmodule : spbo_top_tb
